// [aew_error_word.sv]
// APB error word block of an analog expansion module
`include "aew_map.svh"

// Contract
// - Word bits 15..12 carry no meaning; driven zero, host ignores them.
// - Class in bits 11..9: 000 none, 001 hardware, 010 configuration.
// - With no error the nine extended bits are zero, word X000.
// - Generic hardware fault is X200; power-up reset state is X201.
// - Invalid configuration is discarded, error raised, previous setup kept.
// - Configuration error without specific cause is X400.
// - Two-channel: bad input format X401/X402, bad output format X403/X404.
// - Four-channel: bad range selection channels 0..3 gives X401..X404.
// - Four-channel input only: bad filter channels 0..3 gives X405..X408.
// - Four-channel: bad data format channels 0..3 gives X409..X40C.
// - Codes X210 and X300 are reserved and never produced.
// - Only hardware-class faults (pin, power-up) force every analog output to zero.
// - Configuration errors are non-critical; normal operation continues.
module aew_error_word (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire aew_pkg::aew_apb_req_t apb_req,
  output aew_pkg::aew_apb_rsp_t apb_rsp,
  // Module hardware fault pin, asynchronous
  input wire logic hw_fault_pin,
  // Status and outputs
  output logic [15:0] fault_word,
  output logic [3:0][15:0] analog_out,
  output logic irq
);

  aew_pkg::aew_state_t s;
  aew_pkg::aew_state_t next_s;

  // ==========================================================
  // Register map: byte offsets, one 32-bit word each
  // Word 0x00, read only: [11:9] class, [8:0] extended code
  // Control 0x04: [1:0] variant, 0 two-channel, 1 four-in, 2 four-out
  // Variant 3 is refused as a general setup error; the old one is kept
  // Control [4] written 1 leaves the power-up state and reads back 0
  // Control [5] filtered fault pin and [6] power-up state, read only
  // Setup 0x08, write only: [7:0] range, [15:8] filter, [23:16] format
  // Two bits per channel, channel 0 lowest; the value 3 is invalid
  // Active setup 0x0c, read only: the setup in force
  // Status 0x10, read only, sticky: [0] pin rose, [1] refused, [2] taken
  // Clear 0x14, write only: a 1 clears that status bit
  // Enable 0x18, read and write: [2:0] interrupt enables
  // Output 0x1c, write only: [17:16] channel, [15:0] value
  // Unmapped or misaligned addresses answer pslverr and read zero.
  // Writes to read-only registers are dropped without an error.
  // Word priority: fault pin, then power-up state, then setup error.
  // Changing the variant does not recheck the setup already in force.

  // ==========================================================
  // Bus timing
  // The access cycle forms the answer from the registered state, and
  // pready, prdata and pslverr stand for the one cycle after it. This
  // costs a wait state on every access but keeps the answer on flops.
  // A write lands at the edge that samples pready high; the word,
  // outputs and irq show its effect from the following cycle.
  // A fault pin change reaches the word four to five edges later.
  // Status bits are set after the clear is applied, so an event in the
  // clearing cycle is kept.

  // ==========================================================
  // Address decode
  function automatic aew_pkg::aew_reg_t decode(input logic [11:0] a);
    case (a)
      `AEW_OFF_WORD: decode = aew_pkg::AEW_R_WORD;
      `AEW_OFF_CTRL: decode = aew_pkg::AEW_R_CTRL;
      `AEW_OFF_CFG: decode = aew_pkg::AEW_R_CFG;
      `AEW_OFF_CFG_ACT: decode = aew_pkg::AEW_R_CFG_ACT;
      `AEW_OFF_IRQ_ST: decode = aew_pkg::AEW_R_IRQ_ST;
      `AEW_OFF_IRQ_CLR: decode = aew_pkg::AEW_R_IRQ_CLR;
      `AEW_OFF_IRQ_EN: decode = aew_pkg::AEW_R_IRQ_EN;
      `AEW_OFF_AO: decode = aew_pkg::AEW_R_AO;
      default: decode = aew_pkg::AEW_R_NONE;
    endcase
  endfunction

  // ==========================================================
  // Selector scan
  // Returns {bad, channel} for the lowest channel whose selector holds
  // the invalid value; the range, filter and format checks share it.
  function automatic logic [2:0] first_bad(input logic [7:0] f);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (f[2*i +: 2] == `AEW_FLD_BAD) begin
        r = {1'b1, 2'(i)};
      end
    end
    first_bad = r;
  endfunction

  // ==========================================================
  // Configuration check
  // Returns {bad, code}. Later tests overwrite earlier ones, so they run
  // from the highest code down and the lowest failing code is reported.
  function automatic logic [9:0] cfg_check(input aew_pkg::aew_var_t v,
                                           input aew_pkg::aew_cfg_t c);
    logic [9:0] r;
    logic [2:0] bad_fmt;
    logic [2:0] bad_filt;
    logic [2:0] bad_rng;
    r = {1'b0, `AEW_EXT_NONE};
    bad_fmt = first_bad(c.fmt);
    bad_filt = first_bad(c.filt);
    bad_rng = first_bad(c.rng);
    if (bad_fmt[2]) begin
      if (v == aew_pkg::AEW_V2CH) begin
        r = {1'b1, `AEW_EXT_FMT2CH0 + 9'(bad_fmt[1:0])};
      end else begin
        r = {1'b1, `AEW_EXT_FMT0 + 9'(bad_fmt[1:0])};
      end
    end
    // Filters exist only on the input variant
    if (bad_filt[2] && v == aew_pkg::AEW_V4IN) begin
      r = {1'b1, `AEW_EXT_FILT0 + 9'(bad_filt[1:0])};
    end
    if (bad_rng[2] && v != aew_pkg::AEW_V2CH) begin
      r = {1'b1, `AEW_EXT_RANGE0 + 9'(bad_rng[1:0])};
    end
    cfg_check = r;
  endfunction

  // ==========================================================
  // Read-back; write-only registers read as zero
  function automatic logic [31:0] read_back(input aew_pkg::aew_reg_t r,
                                            input aew_pkg::aew_state_t st);
    logic [31:0] d;
    case (r)
      aew_pkg::AEW_R_WORD: d = {16'h0000, st.word};
      aew_pkg::AEW_R_CTRL: d = {25'h0, st.por, st.hw, 2'h0, 1'b0, st.variant};
      aew_pkg::AEW_R_CFG_ACT: d = {8'h00, st.cfg};
      aew_pkg::AEW_R_IRQ_ST: d = {29'h0, st.irq_st};
      aew_pkg::AEW_R_IRQ_EN: d = {29'h0, st.irq_en};
      default: d = 32'h00000000;
    endcase
    read_back = d;
  endfunction

  // ==========================================================
  // Fault pin filter
  // Stage one may be metastable, so only the shift reads it; a level
  // counts once stages two and three agree, else the old one is held.
  function automatic logic pin_level(input logic [2:0] sync, input logic held);
    pin_level = held;
    if (sync[1] == sync[2]) begin
      pin_level = sync[1];
    end
  endfunction

  // ==========================================================
  // Output forcing
  // Only hardware-class faults zero the channels: a refused setup is
  // recoverable, and the channels keep running on the setup in force.
  function automatic logic [15:0] out_level(input logic zero, input logic [15:0] v);
    out_level = v;
    if (zero) begin
      out_level = 16'h0000;
    end
  endfunction

  // ==========================================================
  // Error word
  // Class and extended code come from one place and leave the state
  // register together, so no read sees a class with a stale code.
  function automatic aew_pkg::aew_word_t compose_word(input logic hw,
                                                      input logic por,
                                                      input logic err,
                                                      input logic [8:0] code);
    aew_pkg::aew_word_t w;
    w.dont_care = `AEW_DONT_CARE;
    if (hw) begin
      w.cls = aew_pkg::AEW_HW;
      w.ext = `AEW_EXT_NONE;
    end else if (por) begin
      w.cls = aew_pkg::AEW_HW;
      w.ext = `AEW_EXT_PWRUP;
    end else if (err) begin
      w.cls = aew_pkg::AEW_CFG;
      w.ext = code;
    end else begin
      w.cls = aew_pkg::AEW_NONE;
      w.ext = `AEW_EXT_NONE;
    end
    compose_word = w;
  endfunction

  // ==========================================================
  // Next state
  logic acc;
  logic done;
  logic wr;
  logic [9:0] chk;
  logic [2:0] ev;
  aew_pkg::aew_reg_t sel;
  aew_pkg::aew_var_t wvar;
  logic [1:0] ch;

  always_comb begin
    next_s = s;
    acc = apb_req.psel & apb_req.penable;
    done = acc & s.rsp.pready;
    wr = done & apb_req.pwrite;
    sel = decode(apb_req.paddr);
    chk = cfg_check(s.variant, apb_req.pwdata[23:0]);
    wvar = aew_pkg::aew_var_t'(apb_req.pwdata[`AEW_CTRL_VAR_LSB +: 2]);
    ch = apb_req.pwdata[`AEW_AO_CH_LSB +: 2];
    ev = 3'h0;

    next_s.sync = {s.sync[1:0], hw_fault_pin};
    next_s.hw = pin_level(s.sync, s.hw);
    ev[0] = next_s.hw & ~s.hw;

    // One wait state: data is prepared while pready rises
    next_s.rsp.pready = acc & ~s.rsp.pready;
    if (acc & ~s.rsp.pready) begin
      next_s.rsp.pslverr = (sel == aew_pkg::AEW_R_NONE);
      next_s.rsp.prdata = read_back(sel, s);
    end else begin
      next_s.rsp.pslverr = 1'b0;
      next_s.rsp.prdata = 32'h00000000;
    end

    if (wr) begin
      case (sel)
        aew_pkg::AEW_R_CTRL: begin
          if (apb_req.pwdata[`AEW_CTRL_ACK_BIT]) begin
            next_s.por = 1'b0;
          end
          // An unknown variant is refused like any bad setting
          if (wvar == aew_pkg::AEW_VBAD) begin
            next_s.cfg_err = 1'b1;
            next_s.cfg_code = `AEW_EXT_NONE;
            ev[1] = 1'b1;
          end else begin
            next_s.variant = wvar;
          end
        end
        aew_pkg::AEW_R_CFG: begin
          if (chk[9]) begin
            // Active setup stays as it was; the module keeps running
            next_s.cfg_err = 1'b1;
            next_s.cfg_code = chk[8:0];
            ev[1] = 1'b1;
          end else begin
            next_s.cfg = apb_req.pwdata[23:0];
            next_s.cfg_err = 1'b0;
            ev[2] = 1'b1;
          end
        end
        aew_pkg::AEW_R_IRQ_CLR: next_s.irq_st = s.irq_st & ~apb_req.pwdata[2:0];
        aew_pkg::AEW_R_IRQ_EN: next_s.irq_en = apb_req.pwdata[2:0];
        aew_pkg::AEW_R_AO: next_s.ao[ch] = apb_req.pwdata[15:0];
        default: next_s.irq_en = s.irq_en;
      endcase
    end

    // Events after the clear so a coincident event is kept
    next_s.irq_st = next_s.irq_st | ev;
    next_s.irq = |(next_s.irq_st & next_s.irq_en);

    // Whole word built in one place and registered at once
    next_s.word = compose_word(next_s.hw, next_s.por, next_s.cfg_err, next_s.cfg_code);

    // Hardware-class faults zero the outputs; config errors do not
    for (int i = 0; i < 4; i++) begin
      next_s.ao_q[i] = out_level(next_s.hw | next_s.por, next_s.ao[i]);
    end
  end

  // ==========================================================
  // State register
  // Reset enters the power-up state, so the word reads X201 until the
  // control write that acknowledges it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.sync <= 3'h0;
      s.hw <= 1'b0;
      s.por <= 1'b1;
      s.variant <= aew_pkg::aew_var_t'(`AEW_VAR_RST);
      s.cfg <= `AEW_CFG_RST;
      s.cfg_err <= 1'b0;
      s.cfg_code <= `AEW_EXT_NONE;
      s.word <= `AEW_WORD_RST;
      s.ao <= '0;
      s.ao_q <= '0;
      s.irq_st <= 3'h0;
      s.irq_en <= 3'h0;
      s.irq <= 1'b0;
      s.rsp <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign apb_rsp = s.rsp;
  assign fault_word = s.word;
  assign analog_out = s.ao_q;
  assign irq = s.irq;

endmodule

// [aew_error_word_properties.sv]
// Concurrent checks on the ports of the error word block
module aew_error_word_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire aew_pkg::aew_apb_req_t apb_req,
  input wire aew_pkg::aew_apb_rsp_t apb_rsp,
  // Status
  input wire logic [15:0] fault_word,
  input wire logic [3:0][15:0] analog_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Word layout
  chk_dc_zero: assert property (fault_word[15:12] == 4'h0)
    else $error("Upper digit of error word not zero");
  chk_cls_legal: assert property (fault_word[11:9] <= 3'h2)
    else $error("Undefined error class");
  chk_none_ext: assert property (fault_word[11:9] == 3'h0 |-> fault_word[8:0] == 9'h000)
    else $error("Detail set without class");
  chk_hw_ext: assert property (fault_word[11:9] == 3'h1 |-> fault_word[8:0] <= 9'h001)
    else $error("Hardware detail out of set");
  chk_cfg_ext: assert property (fault_word[11:9] == 3'h2 |-> fault_word[8:0] <= 9'h00c)
    else $error("Configuration detail out of set");
  chk_hw_outputs: assert property (fault_word[11:9] == 3'h1 |-> analog_out == '0)
    else $error("Outputs live during hardware fault");
  // ==========================================================
  // Bus timing: one wait state, one-cycle answer
  chk_ready_wait: assert property ($rose(apb_req.psel && apb_req.penable)
    |-> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("Answer not one cycle after access");
  chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("Ready held over one cycle");
endmodule

bind aew_error_word aew_error_word_properties chk_u (
  .pclk(pclk),
  .presetn(presetn),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .fault_word(fault_word),
  .analog_out(analog_out)
);

// [aew_error_word_tb.sv]
// Self-checking bench for the error word block
module aew_error_word_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic hw_fault_pin = 1'b0;
  aew_pkg::aew_apb_req_t apb_req = '0;
  aew_pkg::aew_apb_rsp_t apb_rsp;
  logic [15:0] fault_word;
  logic [3:0][15:0] analog_out;
  logic irq;
  logic [11:0] code;
  logic [31:0] rd;
  logic er;
  int num_errors = 0;
  int n_compared = 0;
  always #25 pclk = ~pclk;
  aew_error_word dut_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .hw_fault_pin(hw_fault_pin), .fault_word(fault_word),
    .analog_out(analog_out), .irq(irq));
  aew_host_model host_u (.fault_word(fault_word), .code(code));
  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds the request until pready is sampled, then settles to the negedge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic stop_test;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("word", 64'h201, 64'(code));
    chk("aout", 64'h0, analog_out);
    apb(1'b1, 12'h004, 32'h10);
    chk("word", 64'h000, 64'(fault_word[11:0]));
    apb(1'b1, 12'h01c, 32'h0001_1234);
    apb(1'b1, 12'h018, 32'h1);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b1, 12'h008, 32'h0012_2104);
    for (int f = 0; f < 3; f++) begin
      for (int c = 0; c < 4; c++) begin
        apb(1'b1, 12'h008, 32'h3 << (8 * f + 2 * c));
        chk("word", 64'(12'h401 + 4 * f + c), 64'(code));
        apb(1'b0, 12'h00c, 32'h0);
        chk("cfg_act", 64'h12_2104, 64'(rd));
        chk("aout", 64'h1234_0000, analog_out);
      end
    end
    // Filter selection is not checked on the output variant
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b1, 12'h008, 32'h0000_0300);
    chk("word", 64'h0, 64'(code));
    apb(1'b1, 12'h004, 32'h0);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 12'h008, 32'h3 << (16 + 2 * c));
      chk("word", 64'(12'h401 + c), 64'(code));
    end
    apb(1'b1, 12'h004, 32'h3);
    chk("word", 64'h400, 64'(code));
    apb(1'b0, 12'h004, 32'h0);
    chk("variant", 64'h0, 64'(rd[1:0]));
    chk("irq", 64'h0, 64'(irq));
    @(posedge pclk);
    hw_fault_pin <= 1'b1;
    repeat (6) @(negedge pclk);
    chk("word", 64'h200, 64'(code));
    chk("aout", 64'h0, analog_out);
    chk("irq", 64'h1, 64'(irq));
    apb(1'b1, 12'h018, 32'h0);
    chk("irq", 64'h0, 64'(irq));
    apb(1'b1, 12'h018, 32'h1);
    chk("irq", 64'h1, 64'(irq));
    apb(1'b1, 12'h014, 32'h1);
    chk("irq", 64'h0, 64'(irq));
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", 64'h1, 64'(er));
    chk("rdata", 64'h0, 64'(rd));
    stop_test();
  end
  // Whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    stop_test();
  end
endmodule

// [aew_host_model.sv]
// Controller-side model that decodes the reported error word
module aew_host_model (
  // Reported word
  input wire logic [15:0] fault_word,
  // Decoded class and detail
  output logic [11:0] code
);
  // ==========================================================
  // Decode
  always_comb begin
    code = {fault_word[11:9], 9'h000};
    // Detail is meaningless while no class is set
    if (fault_word[11:9] != 3'h0) begin
      code[8:0] = fault_word[8:0];
    end
  end
endmodule

// [aew_map.svh]
// Register offsets, field positions, codes and reset values of the error word block
`ifndef AEW_MAP_SVH
`define AEW_MAP_SVH
// ==========================================================
// Register byte offsets
`define AEW_OFF_WORD 12'h000
`define AEW_OFF_CTRL 12'h004
`define AEW_OFF_CFG 12'h008
`define AEW_OFF_CFG_ACT 12'h00c
`define AEW_OFF_IRQ_ST 12'h010
`define AEW_OFF_IRQ_CLR 12'h014
`define AEW_OFF_IRQ_EN 12'h018
`define AEW_OFF_AO 12'h01c
// ==========================================================
// Error classes and extended codes
`define AEW_CLS_NONE 3'h0
`define AEW_CLS_HW 3'h1
`define AEW_CLS_CFG 3'h2
`define AEW_EXT_NONE 9'h000
`define AEW_EXT_PWRUP 9'h001
`define AEW_EXT_RANGE0 9'h001
`define AEW_EXT_FILT0 9'h005
`define AEW_EXT_FMT0 9'h009
`define AEW_EXT_FMT2CH0 9'h001
`define AEW_DONT_CARE 4'h0
// ==========================================================
// Variants and field layouts
`define AEW_VAR_2CH 2'h0
`define AEW_VAR_4IN 2'h1
`define AEW_VAR_4OUT 2'h2
`define AEW_VAR_BAD 2'h3
`define AEW_FLD_BAD 2'h3
`define AEW_CTRL_VAR_LSB 0
`define AEW_CTRL_ACK_BIT 4
`define AEW_CTRL_HW_BIT 5
`define AEW_CTRL_POR_BIT 6
`define AEW_AO_CH_LSB 16
// ==========================================================
// Reset values
`define AEW_WORD_RST 16'h0201
`define AEW_CFG_RST 24'h000000
`define AEW_VAR_RST 2'h0
`endif

// [aew_pkg.sv]
// Types shared by the error word block
package aew_pkg;
`include "aew_map.svh"

  typedef enum logic [2:0] {
    AEW_NONE = `AEW_CLS_NONE,
    AEW_HW = `AEW_CLS_HW,
    AEW_CFG = `AEW_CLS_CFG
  } aew_cls_t;

  typedef enum logic [1:0] {
    AEW_V2CH = `AEW_VAR_2CH,
    AEW_V4IN = `AEW_VAR_4IN,
    AEW_V4OUT = `AEW_VAR_4OUT,
    AEW_VBAD = `AEW_VAR_BAD
  } aew_var_t;

  typedef struct packed {
    logic [3:0] dont_care;
    aew_cls_t cls;
    logic [8:0] ext;
  } aew_word_t;

  // Two-bit selectors per channel; channel 0 in the low bits of each byte
  typedef struct packed {
    logic [7:0] fmt;
    logic [7:0] filt;
    logic [7:0] rng;
  } aew_cfg_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } aew_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } aew_apb_rsp_t;

  typedef enum logic [3:0] {
    AEW_R_WORD, AEW_R_CTRL, AEW_R_CFG, AEW_R_CFG_ACT,
    AEW_R_IRQ_ST, AEW_R_IRQ_CLR, AEW_R_IRQ_EN, AEW_R_AO, AEW_R_NONE
  } aew_reg_t;

  typedef struct packed {
    logic [2:0] sync;
    logic hw;
    logic por;
    aew_var_t variant;
    aew_cfg_t cfg;
    logic cfg_err;
    logic [8:0] cfg_code;
    aew_word_t word;
    logic [3:0][15:0] ao;
    logic [3:0][15:0] ao_q;
    logic [2:0] irq_st;
    logic [2:0] irq_en;
    logic irq;
    aew_apb_rsp_t rsp;
  } aew_state_t;
endpackage
